/* inc/eeec_regs.vh */
`ifndef EEEC_REGS_VH
`define EEEC_REGS_VH

// register indices; the avalon byte address is four times the index
`define EEEC_IDX_CFG3       16'h04D1
`define EEEC_IDX_LBW1       16'h04D4
`define EEEC_IDX_LBW2       16'h04D5
`define EEEC_IDX_LBW3       16'h04D6
`define EEEC_IDX_PCS_CTRL   16'h3000
`define EEEC_IDX_PCS_STAT   16'h3001
`define EEEC_IDX_EEE_CAP    16'h3014
`define EEEC_IDX_WAKE_CNT   16'h3016
`define EEEC_IDX_ADV        16'h703C
`define EEEC_IDX_LP_ABIL    16'h703D

// eee_config_three fields
`define EEEC_CFG3_BYPASS    3
`define EEEC_CFG3_NP_DIS    2
`define EEEC_CFG3_RX_SHDN   1
`define EEEC_CFG3_CAP_EN    0
`define EEEC_CFG3_RST       16'h018B

// reserved loop bandwidth registers
`define EEEC_LBW1_RST       16'h7220
`define EEEC_LBW2_RST       16'hFBC1
`define EEEC_LBW3_RST       16'h01C1

// pcs_control_one fields
`define EEEC_PCS_SOFT_RST   15
`define EEEC_PCS_RXCLK_STOP 10
`define EEEC_PCS_CTRL_RST   16'h0400

// pcs_status_one fields
`define EEEC_STAT_TX_RCVD   11
`define EEEC_STAT_RX_RCVD   10
`define EEEC_STAT_TX_NOW    9
`define EEEC_STAT_RX_NOW    8
`define EEEC_STAT_TXCLK_OK  6

// eee_capability fixed value: 100base-tx yes, 1000base-t no
`define EEEC_CAP_VALUE      16'h0002

// advertisement / partner ability field
`define EEEC_ADV_100TX      1

// wake fault counter
`define EEEC_WCNT_RST       16'h0000

`endif

/* hw/eeec_wake_cnt.v */
`timescale 1ns/1ps
`default_nettype none

// saturating event counter with clear-on-read
module eeec_wake_cnt #(
	parameter WIDTH = 16
) (
	input  wire             mclk,
	input  wire             clr_all,
	input  wire             inc,
	input  wire             rd_clr,
	output reg  [WIDTH-1:0] count_q
);

	wire at_max; // counter already full
	assign at_max = &count_q;

	// clear on read, but an event in the same cycle is kept as one
	always @(posedge mclk) begin
		if (clr_all) begin
			count_q <= {WIDTH{1'b0}};
		end else if (rd_clr) begin
			count_q <= inc ? {{(WIDTH-1){1'b0}}, 1'b1} : {WIDTH{1'b0}};
		end else if (inc && !at_max) begin
			count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
		end
		// at all ones further events are dropped, no wrap
	end

endmodule

`default_nettype wire

/* hw/eeec_regs.v */
// Summary of operation
// - bypass set: enable bit alone sets advertisement
// - next-page-disable set refuses incoming eee next pages
// - shutdown bit powers down analog rx during quiet
// - enable set: negotiate per advertise/partner registers
// - enable clear: capability and mmd7 registers ignored
// - rx clock stoppable bit permits rx clock stop
// - status bits 11/10 latch lpi received
// - status bits 9/8 show lpi now
// - status bit 6 reads one always
// - capability reads 100tx one, 1000t zero
// - counter increments on each wake fault
// - counter clears on read, saturates
// - pcs reset zeroes wake fault counter
// - advertise bit 1 strap loaded, default one
// - partner ability bit 1 mirrors partner advert
`timescale 1ns/1ps
`default_nettype none
`include "eeec_regs.vh"

module eeec_regs #(
	parameter CNT_WIDTH = 16,
	parameter SYNC_LEN  = 3
) (
	input  wire        mclk,
	input  wire        rst,
	// avalon-mm slave, byte addressed
	input  wire [17:0] avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest,
	// strap pins, asynchronous
	input  wire        strap_eee_en,
	input  wire        strap_adv_100,
	// status from pcs and autoneg, same clock
	input  wire        tx_lpi_now,
	input  wire        rx_lpi_now,
	input  wire        rx_lpi_quiet,
	input  wire        lp_adv_100,
	input  wire        wake_fault,
	// control toward pcs, autoneg and analog
	output reg         an_eee_enable,
	output reg         an_adv_100,
	output reg         an_np_accept,
	output reg         eee_resolved,
	output reg         rx_analog_pwrdn,
	output reg         rx_clk_stop_ok,
	output reg         pcs_soft_rst
);

	// ---------------- strap synchroniser ----------------
	wire [1:0] strap_pin; // raw strap levels
	assign strap_pin = {strap_adv_100, strap_eee_en};

	reg  [SYNC_LEN-1:0] sync_q [0:1]; // per-strap shift chain
	wire [1:0]          strap_stable; // second and third agree
	wire [1:0]          strap_val;    // agreed level

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
			// three flops; only the last two are compared
			always @(posedge mclk) begin
				sync_q[gi] <= {sync_q[gi][SYNC_LEN-2:0], strap_pin[gi]};
			end
			assign strap_stable[gi] = sync_q[gi][1] == sync_q[gi][2];
			assign strap_val[gi]    = sync_q[gi][2];
		end
	endgenerate

	reg       strap_pend_q; // straps not yet captured
	reg [1:0] strap_lat_q;  // captured strap levels

	// capture straps after reset release, once levels settle
	always @(posedge mclk) begin
		if (rst) begin
			strap_pend_q <= 1'b1;
			strap_lat_q  <= 2'b11;
		end else if (strap_pend_q && (&strap_stable)) begin
			strap_pend_q <= 1'b0;
			strap_lat_q  <= strap_val;
		end
	end

	wire strap_load; // one-cycle load of strap-backed bits
	assign strap_load = strap_pend_q & (&strap_stable);

	// ---------------- avalon handshake ----------------
	reg ack_q; // one wait state, then answer

	// waitrequest drops one cycle after the request appears
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

	always @(posedge mclk) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
		end
	end

	wire        wr_fire; // write takes effect at this edge
	wire        rd_take; // read data captured, side effects run
	wire [15:0] idx;     // register index
	assign wr_fire = avs_write & ack_q;
	assign rd_take = avs_read & ~ack_q;
	assign idx     = avs_address[17:2];

	// byte-lane merge of the low half word
	function [15:0] merge16;
		input [15:0] old;
		input [15:0] wd;
		input [1:0]  be;
		begin
			merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
		end
	endfunction

	wire [15:0] wr_val; // write data, unwritten lanes zero
	assign wr_val = merge16(16'h0000, avs_writedata[15:0], avs_byteenable[1:0]);

	// ---------------- address decode ----------------
	reg hit_cfg3;
	reg hit_lbw1;
	reg hit_lbw2;
	reg hit_lbw3;
	reg hit_pctl;
	reg hit_adv;
	reg hit_stat;
	reg hit_wcnt;

	// writable registers and the read-clear status and counter need a hit
	always @* begin
		hit_cfg3 = 1'b0;
		hit_lbw1 = 1'b0;
		hit_lbw2 = 1'b0;
		hit_lbw3 = 1'b0;
		hit_pctl = 1'b0;
		hit_adv  = 1'b0;
		hit_stat = 1'b0;
		hit_wcnt = 1'b0;
		if (idx == `EEEC_IDX_CFG3) begin
			hit_cfg3 = 1'b1;
		end else if (idx == `EEEC_IDX_LBW1) begin
			hit_lbw1 = 1'b1;
		end else if (idx == `EEEC_IDX_LBW2) begin
			hit_lbw2 = 1'b1;
		end else if (idx == `EEEC_IDX_LBW3) begin
			hit_lbw3 = 1'b1;
		end else if (idx == `EEEC_IDX_PCS_CTRL) begin
			hit_pctl = 1'b1;
		end else if (idx == `EEEC_IDX_ADV) begin
			hit_adv = 1'b1;
		end else if (idx == `EEEC_IDX_PCS_STAT) begin
			hit_stat = 1'b1;
		end else if (idx == `EEEC_IDX_WAKE_CNT) begin
			hit_wcnt = 1'b1;
		end
	end

	// ---------------- vendor registers ----------------
	// these survive a pcs reset; only hardware reset touches them
	reg [15:0] cfg3_q; // eee_config_three
	reg [15:0] lbw1_q; // loop_bandwidth_ctrl_one
	reg [15:0] lbw2_q; // loop_bandwidth_ctrl_two
	reg [15:0] lbw3_q; // loop_bandwidth_ctrl_three

	always @(posedge mclk) begin
		if (rst) begin
			cfg3_q <= `EEEC_CFG3_RST;
			lbw1_q <= `EEEC_LBW1_RST;
			lbw2_q <= `EEEC_LBW2_RST;
			lbw3_q <= `EEEC_LBW3_RST;
		end else begin
			if (wr_fire && hit_cfg3) begin
				cfg3_q <= merge16(cfg3_q, avs_writedata[15:0], avs_byteenable[1:0]);
			end else if (strap_load) begin
				// strap overrides only until software writes
				cfg3_q[`EEEC_CFG3_CAP_EN] <= strap_val[0];
			end
			if (wr_fire && hit_lbw1) begin
				lbw1_q <= merge16(lbw1_q, avs_writedata[15:0], avs_byteenable[1:0]);
			end
			if (wr_fire && hit_lbw2) begin
				lbw2_q <= merge16(lbw2_q, avs_writedata[15:0], avs_byteenable[1:0]);
			end
			if (wr_fire && hit_lbw3) begin
				lbw3_q <= merge16(lbw3_q, avs_writedata[15:0], avs_byteenable[1:0]);
			end
		end
	end

	// ---------------- pcs soft reset ----------------
	reg  soft_rst_q; // self-clearing, high one cycle
	wire mmd_rst;    // clears mmd3 and pcs state; mmd7 advert reloads on soft_rst_q

	// a written one pulses for a single cycle, then clears itself
	always @(posedge mclk) begin
		if (rst) begin
			soft_rst_q <= 1'b0;
		end else begin
			soft_rst_q <= wr_fire & hit_pctl & wr_val[`EEEC_PCS_SOFT_RST];
		end
	end

	assign mmd_rst = rst | soft_rst_q;

	// ---------------- mmd3 / mmd7 registers ----------------
	reg rxclk_stop_q; // receive clock stoppable control
	reg adv_100_q;    // advertise 100base-tx eee
	reg tx_rcvd_q;    // tx pcs has seen lpi
	reg rx_rcvd_q;    // rx pcs has seen lpi
	reg stat_rd_q;    // status read captured last edge

	// bits 10 and 15 take writes, 15 self-clears; reserved bits hold zero
	always @(posedge mclk) begin
		if (mmd_rst) begin
			rxclk_stop_q <= 1'b1;
		end else if (wr_fire && hit_pctl && avs_byteenable[1]) begin
			rxclk_stop_q <= avs_writedata[`EEEC_PCS_RXCLK_STOP];
		end
	end

	// pcs reset reloads the captured strap, not the default
	always @(posedge mclk) begin
		if (rst) begin
			adv_100_q <= 1'b1;
		end else if (soft_rst_q) begin
			adv_100_q <= strap_lat_q[1];
		end else if (wr_fire && hit_adv && avs_byteenable[0]) begin
			adv_100_q <= avs_writedata[`EEEC_ADV_100TX];
		end else if (strap_load) begin
			adv_100_q <= strap_val[1];
		end
	end

	// latched lpi seen flags; a new lpi beats the read clear
	always @(posedge mclk) begin
		if (mmd_rst) begin
			tx_rcvd_q <= 1'b0;
			rx_rcvd_q <= 1'b0;
		end else begin
			tx_rcvd_q <= tx_lpi_now | (tx_rcvd_q & ~stat_rd_q);
			rx_rcvd_q <= rx_lpi_now | (rx_rcvd_q & ~stat_rd_q);
		end
	end

	// status read-clear lands one edge after data is captured
	always @(posedge mclk) begin
		stat_rd_q <= 1'b0;
		if (!rst && rd_take && hit_stat) begin
			stat_rd_q <= 1'b1;
		end
	end

	// ---------------- wake fault counter ----------------
	wire [CNT_WIDTH-1:0] wcnt; // current count

	eeec_wake_cnt #(
		.WIDTH   (CNT_WIDTH)
	) u_wcnt (
		.mclk    (mclk),
		.clr_all (mmd_rst),
		.inc     (wake_fault),
		.rd_clr  (rd_take & hit_wcnt),
		.count_q (wcnt)
	);

	// ---------------- readback ----------------
	reg [15:0] rd_val; // value of the addressed register

	// unmapped indices read zero; reserved bits read zero
	always @* begin
		rd_val = 16'h0000;
		if (idx == `EEEC_IDX_CFG3) begin
			rd_val = cfg3_q;
		end else if (idx == `EEEC_IDX_LBW1) begin
			rd_val = lbw1_q;
		end else if (idx == `EEEC_IDX_LBW2) begin
			rd_val = lbw2_q;
		end else if (idx == `EEEC_IDX_LBW3) begin
			rd_val = lbw3_q;
		end else if (idx == `EEEC_IDX_PCS_CTRL) begin
			rd_val[`EEEC_PCS_SOFT_RST]   = soft_rst_q;
			rd_val[`EEEC_PCS_RXCLK_STOP] = rxclk_stop_q;
		end else if (idx == `EEEC_IDX_PCS_STAT) begin
			rd_val[`EEEC_STAT_TX_RCVD]  = tx_rcvd_q;
			rd_val[`EEEC_STAT_RX_RCVD]  = rx_rcvd_q;
			rd_val[`EEEC_STAT_TX_NOW]   = tx_lpi_now;
			rd_val[`EEEC_STAT_RX_NOW]   = rx_lpi_now;
			rd_val[`EEEC_STAT_TXCLK_OK] = 1'b1;
		end else if (idx == `EEEC_IDX_EEE_CAP) begin
			rd_val = `EEEC_CAP_VALUE;
		end else if (idx == `EEEC_IDX_WAKE_CNT) begin
			rd_val = wcnt[15:0];
		end else if (idx == `EEEC_IDX_ADV) begin
			rd_val[`EEEC_ADV_100TX] = adv_100_q;
		end else if (idx == `EEEC_IDX_LP_ABIL) begin
			rd_val[`EEEC_ADV_100TX] = lp_adv_100;
		end
	end

	// data captured with the wait state; stands while the master samples
	always @(posedge mclk) begin
		if (rst) begin
			avs_readdata <= 32'h00000000;
		end else if (rd_take) begin
			avs_readdata <= {16'h0000, rd_val};
		end
	end

	// ---------------- control outputs ----------------
	wire cap_en;  // eee capability enable
	wire bypass;  // advertise bypass
	wire adv_eff; // advertised 100tx eee

	assign cap_en = cfg3_q[`EEEC_CFG3_CAP_EN];
	assign bypass = cfg3_q[`EEEC_CFG3_BYPASS];
	// disabled eee masks the mmd registers entirely
	assign adv_eff = cap_en & (bypass | adv_100_q);

	// registered so autoneg and analog see clean levels
	always @(posedge mclk) begin
		if (rst) begin
			an_eee_enable   <= 1'b0;
			an_adv_100      <= 1'b0;
			an_np_accept    <= 1'b0;
			eee_resolved    <= 1'b0;
			rx_analog_pwrdn <= 1'b0;
			rx_clk_stop_ok  <= 1'b0;
			pcs_soft_rst    <= 1'b0;
		end else begin
			an_eee_enable   <= cap_en;
			an_adv_100      <= adv_eff;
			an_np_accept    <= ~cfg3_q[`EEEC_CFG3_NP_DIS];
			// resolution needs both ends when mmd registers
			eee_resolved    <= adv_eff & (bypass | lp_adv_100);
			rx_analog_pwrdn <= cap_en & cfg3_q[`EEEC_CFG3_RX_SHDN] & rx_lpi_quiet;
			rx_clk_stop_ok  <= cap_en & rxclk_stop_q & rx_lpi_now;
			pcs_soft_rst    <= soft_rst_q;
		end
	end

endmodule

`default_nettype wire

/* verification/eeec_regs_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "eeec_regs.vh"
// bus timing and control output relations
module eeec_regs_checker (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic [17:0] avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        rx_lpi_quiet,
	input wire logic        rx_lpi_now,
	input wire logic        an_eee_enable,
	input wire logic        an_adv_100,
	input wire logic        eee_resolved,
	input wire logic        rx_analog_pwrdn,
	input wire logic        rx_clk_stop_ok,
	input wire logic        pcs_soft_rst
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	wire logic [15:0] idx = avs_address[17:2]; // register index
	wire logic        acc = avs_read && !avs_waitrequest; // read completing
	a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("more than one wait state");
	a_upper_zero: assert property (avs_readdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	a_cap_fixed: assert property (acc && idx == 16'h3014 |-> avs_readdata[15:0] == 16'h0002)
		else $error("capability value wrong");
	a_txclk_ok: assert property (acc && idx == 16'h3001 |-> avs_readdata[6])
		else $error("tx clock stoppable bit low");
	a_adv_needs_en: assert property (an_adv_100 |-> an_eee_enable)
		else $error("advertising while disabled");
	a_resolve_adv: assert property (eee_resolved |-> an_adv_100)
		else $error("resolved without advertising");
	a_pwrdn_cause: assert property (rx_analog_pwrdn |-> an_eee_enable && $past(rx_lpi_quiet))
		else $error("rx power down without quiet");
	a_clkstop_cause: assert property (rx_clk_stop_ok |-> $past(rx_lpi_now))
		else $error("rx clock stop without lpi");
	a_soft_pulse: assert property ($rose(pcs_soft_rst) |=> !pcs_soft_rst)
		else $error("soft reset pulse too long");
	a_soft_follow: assert property (avs_write && !avs_waitrequest && idx == 16'h3000
		&& avs_writedata[15] && avs_byteenable[1] |-> ##[1:4] pcs_soft_rst)
		else $error("soft reset not issued");
endmodule
bind eeec_regs eeec_regs_checker u_chk (.mclk(mclk), .rst(rst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .rx_lpi_quiet(rx_lpi_quiet), .rx_lpi_now(rx_lpi_now),
	.an_eee_enable(an_eee_enable), .an_adv_100(an_adv_100), .eee_resolved(eee_resolved),
	.rx_analog_pwrdn(rx_analog_pwrdn), .rx_clk_stop_ok(rx_clk_stop_ok),
	.pcs_soft_rst(pcs_soft_rst));
`default_nettype wire

/* verification/eeec_mac_model.sv */
`timescale 1ns/1ps
`default_nettype none
// pcs/autoneg status source on the same clock
module eeec_mac_model (
	input wire logic        mclk,
	input wire logic [3:0]  lvl_cmd,
	input wire logic        fault_go,
	input wire logic [16:0] fault_n,
	output var logic        tx_lpi_now,
	output var logic        rx_lpi_now,
	output var logic        rx_lpi_quiet,
	output var logic        lp_adv_100,
	output wire logic       wake_fault
);
	logic [16:0] left_q = 17'h00000; // faults still to send
	initial {tx_lpi_now, rx_lpi_now, rx_lpi_quiet, lp_adv_100} = 4'h0;
	// levels follow the command one edge later, like a real pcs
	always @(posedge mclk) begin
		{tx_lpi_now, rx_lpi_now, rx_lpi_quiet, lp_adv_100} <= lvl_cmd;
		if (fault_go) left_q <= fault_n;
		else if (left_q != 17'h00000) left_q <= left_q - 17'h00001;
	end
	// one wake fault per high cycle
	assign wake_fault = (left_q != 17'h00000);
endmodule
`default_nettype wire

/* verification/test_eeec_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module test_eeec_regs;
	logic mclk, rst, avs_read, avs_write, fgo;
	logic [17:0] avs_address;
	logic [31:0] avs_writedata, rd;
	logic [3:0] avs_byteenable, lvl;
	logic [16:0] fn;
	logic st_en, st_adv; // strap pin levels, dropped for the second reset
	wire logic [31:0] avs_readdata;
	wire logic avs_waitrequest, txn, rxn, qt, lpa, wf, en, adv, npa, res, pd, cs, srst;
	int n_errors = 0, comparisons = 0, cyc = 0;
	logic [15:0] ix_t [10] = '{16'h04D1, 16'h04D4, 16'h04D5, 16'h04D6, 16'h3000,
		16'h3001, 16'h3014, 16'h3016, 16'h703C, 16'h703D};
	logic [15:0] rv_t [10] = '{16'h018B, 16'h7220, 16'hFBC1, 16'h01C1, 16'h0400,
		16'h0040, 16'h0002, 16'h0000, 16'h0002, 16'h0000};
	int ro_t [4] = '{5, 6, 7, 9}; // read-only entries
	eeec_regs uut (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .strap_eee_en(st_en),
		.strap_adv_100(st_adv), .tx_lpi_now(txn), .rx_lpi_now(rxn), .rx_lpi_quiet(qt),
		.lp_adv_100(lpa), .wake_fault(wf), .an_eee_enable(en), .an_adv_100(adv),
		.an_np_accept(npa), .eee_resolved(res), .rx_analog_pwrdn(pd), .rx_clk_stop_ok(cs),
		.pcs_soft_rst(srst));
	eeec_mac_model mac (.mclk(mclk), .lvl_cmd(lvl), .fault_go(fgo), .fault_n(fn),
		.tx_lpi_now(txn), .rx_lpi_now(rxn), .rx_lpi_quiet(qt), .lp_adv_100(lpa),
		.wake_fault(wf));
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task results;
		$display("checks %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 90000) begin
			n_errors++;
			results;
		end
	end
	task chk(input string nm, input logic [15:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== {16'h0000, e}) begin
			n_errors++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task chko(input string nm, input logic e, input logic g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s exp %b got %b", nm, e, g);
		end
	endtask
	// one avalon transfer, held until the rising edge that sees waitrequest low
	task bus(input logic w, input logic [15:0] ix, input logic [15:0] d);
		@(posedge mclk);
		avs_address <= {ix, 2'b00};
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= {16'h0000, d};
		@(posedge mclk);
		// no cycle count assumed; only the hang guard ends a stuck wait
		while (avs_waitrequest !== 1'b0) @(posedge mclk);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task wr(input logic [15:0] ix, input logic [15:0] d);
		bus(1'b1, ix, d);
	endtask
	task rdc(input string nm, input logic [15:0] ix, input logic [15:0] e);
		bus(1'b0, ix, 16'h0000);
		chk(nm, e, rd);
	endtask
	task idle(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask
	task flt(input int n);
		@(posedge mclk);
		fn <= n[16:0];
		fgo <= 1'b1;
		@(posedge mclk);
		fgo <= 1'b0;
		repeat (n + 3) @(posedge mclk);
	endtask
	initial begin
		rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 18'h00000;
		avs_writedata = 32'h00000000; avs_byteenable = 4'hF; lvl = 4'h0; fgo = 1'b0;
		fn = 17'h00000;
		st_en = 1'b1;
		st_adv = 1'b1;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		idle(3);
		for (int i = 0; i < 10; i++) rdc("reset value", ix_t[i], rv_t[i]);
		chko("eee enable", 1'b1, en);
		chko("np accept", 1'b1, npa);
		$display("reset values done");
		for (int j = 0; j < 4; j++) begin
			wr(ix_t[ro_t[j]], 16'hFFFF);
			rdc("read-only", ix_t[ro_t[j]], rv_t[ro_t[j]]);
		end
		wr(16'h0100, 16'hFFFF);
		rdc("unmapped", 16'h0100, 16'h0000);
		$display("read-only writes done");
		lvl <= 4'h1;
		wr(16'h703C, 16'h0000);
		idle(2);
		chko("adv bypass", 1'b1, adv);
		chko("resolved", 1'b1, res);
		rdc("partner", 16'h703D, 16'h0002);
		wr(16'h04D1, 16'h018F);
		idle(2);
		chko("np refuse", 1'b0, npa);
		wr(16'h04D1, 16'h0183);
		idle(2);
		chko("adv mmd", 1'b0, adv);
		wr(16'h703C, 16'h0002);
		idle(2);
		chko("adv mmd", 1'b1, adv);
		chko("resolved", 1'b1, res);
		lvl <= 4'h0;
		idle(3);
		chko("resolved", 1'b0, res);
		wr(16'h04D1, 16'h018A);
		idle(2);
		chko("eee off", 1'b0, en);
		chko("adv off", 1'b0, adv);
		wr(16'h04D1, 16'h018B);
		$display("autoneg controls done");
		lvl <= 4'h6;
		idle(3);
		chko("rx powerdown", 1'b1, pd);
		chko("rx clk stop", 1'b1, cs);
		wr(16'h04D1, 16'h0189);
		wr(16'h3000, 16'h0000);
		idle(2);
		chko("rx powerdown", 1'b0, pd);
		chko("rx clk stop", 1'b0, cs);
		wr(16'h3000, 16'h0400);
		wr(16'h04D1, 16'h018B);
		$display("quiet controls done");
		lvl <= 4'hC;
		idle(3);
		rdc("lpi now", 16'h3001, 16'h0F40);
		lvl <= 4'h0;
		idle(3);
		rdc("lpi seen", 16'h3001, 16'h0C40);
		rdc("lpi cleared", 16'h3001, 16'h0040);
		$display("lpi status done");
		flt(5);
		rdc("wake count", 16'h3016, 16'h0005);
		rdc("wake clear", 16'h3016, 16'h0000);
		flt(65540);
		rdc("wake saturate", 16'h3016, 16'hFFFF);
		rdc("wake clear", 16'h3016, 16'h0000);
		$display("wake counter done");
		flt(3);
		wr(16'h04D1, 16'h0184);
		wr(16'h703C, 16'h0000);
		wr(16'h3000, 16'h8000);
		// the pulse reaches the pin one edge after the write lands
		idle(1);
		chko("soft pulse", 1'b1, srst);
		idle(2);
		chko("soft pulse end", 1'b0, srst);
		rdc("pcs ctrl", 16'h3000, 16'h0400);
		rdc("wake zeroed", 16'h3016, 16'h0000);
		rdc("adv restored", 16'h703C, 16'h0002);
		rdc("vendor kept", 16'h04D1, 16'h0184);
		$display("soft reset done");
		// second hardware reset with both straps low
		st_en <= 1'b0;
		st_adv <= 1'b0;
		rst <= 1'b1;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		idle(3);
		rdc("strap cfg", 16'h04D1, 16'h018A);
		rdc("strap adv", 16'h703C, 16'h0000);
		chko("eee strap off", 1'b0, en);
		$display("strap reset done");
		results;
	end
endmodule
`default_nettype wire
